// file: lane_xbar_regs.svh
`ifndef LANE_XBAR_REGS_SVH
`define LANE_XBAR_REGS_SVH

// Summary of operation
// RULE_01: A 3-bit source code n routes physical serial input n to the logical lane.
// RULE_02: Logical lane 4 source is bits [2:0] of the lane 4/5 register, reset 0x4.
// RULE_03: Logical lane 5 source is bits [5:3] of the lane 4/5 register, reset 0x5.
// RULE_04: Logical lane 7 source is the upper field of the lane 6/7 register, reset 0x7.
// RULE_05: Logical lane 6 source is bits [2:0] of the lane 6/7 register, reset 0x6.
// RULE_06: Read-only 8-bit full vector, bit n for input n buffer, zero after reset.
// RULE_07: Read-only 8-bit empty vector, bit n for input n buffer.
// RULE_08: Status bits show live buffer state; reads have no effect, writes ignored.

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LX_ADDR_W          10
`define LX_ADDR_SEL45      10'h30a
`define LX_ADDR_SEL67      10'h30b
`define LX_ADDR_FULL       10'h30c
`define LX_ADDR_EMPTY      10'h30d

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LX_LO_LSB          0
`define LX_HI_LSB          3
`define LX_PICK_W          3
`define LX_RST_PICK4       3'h4
`define LX_RST_PICK5       3'h5
`define LX_RST_PICK6       3'h6
`define LX_RST_PICK7       3'h7
`define LX_RST_FULL        8'h00
`define LX_RST_EMPTY       8'hff

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define LX_NUM_PHYS        8
`define LX_NUM_LOGIC       4
`define LX_FIFO_DEPTH      16
`define LX_LANE_W          32

`endif

// file: lane_xbar_pkg.sv
package lane_xbar_pkg;

  // Source code carried by one logical-lane select field.
  typedef logic [2:0] pick_t;

  // Layout of a two-lane select register: reserved, upper lane, lower lane.
  typedef struct packed {
    logic [1:0] rsvd;
    pick_t      hi;
    pick_t      lo;
  } sel_reg_t;

  // Software register port access kinds.
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b01,
    ACC_READ  = 2'b10
  } acc_t;

endpackage : lane_xbar_pkg

// file: lane_fifo.sv
`timescale 1ns/1ps

// Elastic buffer for one physical input. Storage plus a registered head word,
// so the read data always come straight from a flip-flop.
module lane_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  output logic                  full,
  output logic                  empty
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [PW:0]                 count;
    logic                        head_valid;
    logic [WIDTH-1:0]            head;
    logic                        full;
    logic                        empty;
    logic                        ready;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------

  // The head register counts toward capacity, so full means DEPTH words held
  // in total and the storage array never overruns.
  always_comb begin
    logic       push;
    logic       take;
    logic [PW:0] total;
    push  = 1'b0;
    take  = 1'b0;
    total = '0;
    s_d   = s_q;
    push  = in_valid && !s_q.full;
    take  = !s_q.head_valid || out_ready;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr          = s_q.wptr + 1'b1;
    end
    if (take) begin
      if (s_q.count != '0) begin
        s_d.head       = s_q.mem[s_q.rptr];
        s_d.head_valid = 1'b1;
        s_d.rptr       = s_q.rptr + 1'b1;
      end else begin
        s_d.head_valid = 1'b0;
      end
    end
    s_d.count = s_q.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, take && (s_q.count != '0)};
    total     = s_d.count + {{PW{1'b0}}, s_d.head_valid};
    s_d.full  = (total == (PW+1)'(DEPTH));
    s_d.empty = (total == '0);
    s_d.ready = !s_d.full;
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------

  // Storage contents need no reset; only pointers, the count and flags are cleared.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q            <= s_d;
      s_q.wptr       <= '0;
      s_q.rptr       <= '0;
      s_q.count      <= '0;
      s_q.head_valid <= 1'b0;
      s_q.full       <= 1'b0; // RULE_06
      s_q.empty      <= 1'b1;
      s_q.ready      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.ready; // Kept as its own flop so the top ready pin needs no inverter.
  assign out_valid = s_q.head_valid;
  assign out_data  = s_q.head;
  assign full      = s_q.full;
  assign empty     = s_q.empty;

endmodule // lane_fifo

// file: lane_crossbar.sv
`timescale 1ns/1ps
`include "lane_xbar_regs.svh"

// Upper half of the lane crossbar: each physical serial input feeds its own
// elastic buffer, and logical lanes 4 to 7 each draw words from the buffer
// that their select field names. Lane data arrive already deserialised and on
// clk, so they need no synchroniser.
module lane_crossbar #(
  parameter int LANE_W = `LX_LANE_W,
  parameter int DEPTH  = `LX_FIFO_DEPTH
) (
  input  wire logic                                    clk,
  input  wire logic                                    reset,
  input  wire logic [`LX_ADDR_W-1:0]                   reg_addr,
  input  wire logic [7:0]                              reg_wdata,
  input  wire logic                                    reg_write,
  input  wire logic                                    reg_read,
  output logic      [7:0]                              reg_rdata,
  input  wire logic [`LX_NUM_PHYS-1:0]                 physical_serial_input_valid,
  input  wire logic [`LX_NUM_PHYS-1:0][LANE_W-1:0]     physical_serial_input_data,
  output logic      [`LX_NUM_PHYS-1:0]                 physical_serial_input_ready,
  output logic      [`LX_NUM_LOGIC-1:0]                logical_lane_valid,
  output logic      [`LX_NUM_LOGIC-1:0][LANE_W-1:0]    logical_lane_data,
  input  wire logic [`LX_NUM_LOGIC-1:0]                logical_lane_ready
);
  import lane_xbar_pkg::*;

  localparam int NP = `LX_NUM_PHYS;
  localparam int NL = `LX_NUM_LOGIC;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------

  typedef struct packed {
    sel_reg_t                   sel45;
    sel_reg_t                   sel67;
    logic [7:0]                 rdata;
    logic [NL-1:0]              lane_valid;
    logic [NL-1:0][LANE_W-1:0]  lane_data;
  } xbar_state_t;

  xbar_state_t s_q;
  xbar_state_t s_d;

  logic [NP-1:0]             buf_valid;
  logic [NP-1:0][LANE_W-1:0] buf_data;
  logic [NP-1:0]             buf_pop;
  logic [NP-1:0]             buf_full;
  logic [NP-1:0]             buf_empty;
  logic [NL-1:0]             can_load;
  pick_t [NL-1:0]            pick;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------

  // Source code of logical lane 4+k as held in the select registers.
  function automatic pick_t lane_pick(input sel_reg_t s45, input sel_reg_t s67, input int k);
    pick_t p;
    p = s45.lo;
    case (k)
      0:       p = s45.lo; // RULE_02
      1:       p = s45.hi; // RULE_03
      2:       p = s67.lo; // RULE_05
      3:       p = s67.hi; // RULE_04
      default: p = s45.lo;
    endcase
    return p;
  endfunction

  // Builds a select register from a written byte; reserved bits stay zero.
  function automatic sel_reg_t sel_from_byte(input logic [7:0] b);
    sel_reg_t r;
    r      = '0;
    r.lo   = b[`LX_LO_LSB +: `LX_PICK_W];
    r.hi   = b[`LX_HI_LSB +: `LX_PICK_W];
    r.rsvd = 2'h0;
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Elastic buffers, one per physical input
  // ----------------------------------------------------------------------------

  for (genvar p = 0; p < NP; p++) begin : g_buf
    lane_fifo #(
      .WIDTH (LANE_W),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (physical_serial_input_valid[p]),
      .in_data   (physical_serial_input_data[p]),
      .in_ready  (physical_serial_input_ready[p]),
      .out_valid (buf_valid[p]),
      .out_data  (buf_data[p]),
      .out_ready (buf_pop[p]),
      .full      (buf_full[p]),
      .empty     (buf_empty[p])
    );
  end

  // ----------------------------------------------------------------------------
  // Crossbar arbitration
  // ----------------------------------------------------------------------------

  // A buffer is drained only when every logical lane that names it can take a
  // word, so lanes that share one input stay in step. A buffer named by no
  // lane here is held, and its full flag tells software so.
  always_comb begin
    logic named;
    logic ok;
    named = 1'b0;
    ok    = 1'b1;
    for (int k = 0; k < NL; k++) begin
      pick[k]     = lane_pick(s_q.sel45, s_q.sel67, k);
      can_load[k] = !s_q.lane_valid[k] || logical_lane_ready[k];
    end
    for (int p = 0; p < NP; p++) begin
      named = 1'b0;
      ok    = 1'b1;
      for (int k = 0; k < NL; k++) begin
        if (pick[k] == pick_t'(p)) begin // RULE_01
          named = 1'b1;
          ok    = ok && can_load[k];
        end
      end
      buf_pop[p] = buf_valid[p] && named && ok;
    end
  end

  // ----------------------------------------------------------------------------
  // Next state: lane outputs and register port
  // ----------------------------------------------------------------------------

  always_comb begin
    s_d = s_q;

    // Each logical lane output holds its word until the consumer takes it.
    for (int k = 0; k < NL; k++) begin
      if (can_load[k]) begin
        s_d.lane_valid[k] = buf_pop[pick[k]]; // RULE_01
        if (buf_pop[pick[k]]) begin
          s_d.lane_data[k] = buf_data[pick[k]];
        end
      end
    end

    // Only the two select registers take writes; status writes fall away.
    if (reg_write) begin
      case (reg_addr)
        `LX_ADDR_SEL45: s_d.sel45 = sel_from_byte(reg_wdata); // RULE_02 RULE_03
        `LX_ADDR_SEL67: s_d.sel67 = sel_from_byte(reg_wdata); // RULE_04 RULE_05
        default:        s_d.sel45 = s_q.sel45;                // RULE_08
      endcase
    end

    // Read data are captured one edge after the strobe; status reads sample
    // the buffer flags live and disturb nothing.
    if (reg_read) begin
      case (reg_addr)
        `LX_ADDR_SEL45: s_d.rdata = s_q.sel45;
        `LX_ADDR_SEL67: s_d.rdata = s_q.sel67;
        `LX_ADDR_FULL:  s_d.rdata = buf_full;  // RULE_06 RULE_08
        `LX_ADDR_EMPTY: s_d.rdata = buf_empty; // RULE_07 RULE_08
        default:        s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------

  // Reset routes each logical lane to its same-numbered physical input.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.sel45      <= '{rsvd: 2'h0, hi: `LX_RST_PICK5, lo: `LX_RST_PICK4}; // RULE_02 RULE_03
      s_q.sel67      <= '{rsvd: 2'h0, hi: `LX_RST_PICK7, lo: `LX_RST_PICK6}; // RULE_04 RULE_05
      s_q.rdata      <= 8'h00;
      s_q.lane_valid <= '0;
      s_q.lane_data  <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign logical_lane_valid = s_q.lane_valid;
  assign logical_lane_data  = s_q.lane_data;

endmodule // lane_crossbar

// file: lane_crossbar_asserts.sv
`timescale 1ns/1ps

// Register port and lane handshake checks, seen from the top ports only.
module lane_crossbar_asserts #(
  parameter int LANE_W = 32
) (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic [9:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_write,
  input wire logic                   reg_read,
  input wire logic [7:0]             reg_rdata,
  input wire logic [7:0]             physical_serial_input_ready,
  input wire logic [3:0]             logical_lane_valid,
  input wire logic [3:0][LANE_W-1:0] logical_lane_data,
  input wire logic [3:0]             logical_lane_ready
);
  // ----------------------------------------------------------------------
  // Select shadow
  // ----------------------------------------------------------------------
  // Shadow of both select registers; reserved bits are never kept.
  logic [7:0] sel45_q;
  logic [7:0] sel67_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sel45_q <= 8'h2c;
      sel67_q <= 8'h3e;
    end else if (reg_write) begin
      if (reg_addr == 10'h30a) sel45_q <= {2'h0, reg_wdata[5:0]};
      if (reg_addr == 10'h30b) sel67_q <= {2'h0, reg_wdata[5:0]};
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence read_of(a);
    reg_read && reg_addr == a;
  endsequence
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  sel45_read_a: assert property (read_of(10'h30a) |=> reg_rdata == $past(sel45_q))
    else $error("lane 4/5 select read wrong");
  sel67_read_a: assert property (read_of(10'h30b) |=> reg_rdata == $past(sel67_q))
    else $error("lane 6/7 select read wrong");
  full_read_a: assert property (read_of(10'h30c) |=> reg_rdata == ~$past(physical_serial_input_ready))
    else $error("full flags disagree with ready");
  unmapped_read_a: assert property (reg_read && (reg_addr < 10'h30a || reg_addr > 10'h30d) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_state_a: assert property ($fell(reset) |-> reg_rdata == 8'h00 && &physical_serial_input_ready)
    else $error("state after reset wrong");
  lane_latency_a: assert property ($fell(reset) |-> (logical_lane_valid == 4'h0) [*3])
    else $error("lane word too early after reset");
  // A waiting lane word may neither vanish nor change.
  for (genvar k = 0; k < 4; k++) begin : g_lane
    lane_hold_a: assert property (logical_lane_valid[k] && !logical_lane_ready[k] |=>
      logical_lane_valid[k] && $stable(logical_lane_data[k])) else $error("lane word dropped");
  end
endmodule // lane_crossbar_asserts

bind lane_crossbar lane_crossbar_asserts #(.LANE_W(LANE_W)) lane_crossbar_asserts_i (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .physical_serial_input_ready(physical_serial_input_ready), .logical_lane_valid(logical_lane_valid),
  .logical_lane_data(logical_lane_data), .logical_lane_ready(logical_lane_ready));

// file: lane_tx_model.sv
`timescale 1ns/1ps

// Transmitter stand-in: a word carries its input number in the top byte and a
// running count below, so the bench can tell where any lane word came from.
module lane_tx_model (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [7:0]       enable,
  input  wire logic             slow,
  output logic      [7:0]       valid,
  output logic      [7:0][31:0] data,
  input  wire logic [7:0]       ready
);
  logic [7:0][23:0] count_q;
  // An offered word stands until taken; an idle line inverts its data on every
  // cycle, so a stale value can never pass for fresh data.
  always @(posedge clk) begin
    for (int n = 0; n < 8; n++) begin
      if (reset) begin
        valid[n] <= 1'b0;
        data[n] <= 32'h0;
        count_q[n] <= 24'h0;
      end else if (valid[n] && !ready[n]) begin
        valid[n] <= 1'b1;
      end else if (enable[n] && (!slow || $urandom_range(1) == 1)) begin
        valid[n] <= 1'b1;
        data[n] <= {8'(n), count_q[n]};
        count_q[n] <= count_q[n] + 24'h1;
      end else begin
        valid[n] <= 1'b0;
        data[n] <= ~data[n];
      end
    end
  end
endmodule // lane_tx_model

// file: lane_crossbar_tb.sv
`timescale 1ns/1ps

module lane_crossbar_tb;
  import lane_xbar_pkg::*;
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  logic [9:0]      reg_addr = 10'h0;
  logic [7:0]      reg_wdata = 8'h0;
  logic            reg_write = 1'b0;
  logic            reg_read = 1'b0;
  logic [7:0]      reg_rdata;
  logic [7:0]      in_valid;
  logic [7:0]      in_ready;
  logic [7:0]      tx_en = 8'h0;
  logic            tx_slow = 1'b0;
  logic            drain = 1'b1;
  logic [7:0][31:0] in_data;
  logic [3:0]      lane_valid;
  logic [3:0]      lane_ready = 4'h0;
  logic [3:0][31:0] lane_data;
  sel_reg_t        sel45_m = 8'h2c;
  sel_reg_t        sel67_m = 8'h3e;
  int              fail_count = 0;
  int              cmp_count = 0;
  logic [3:0][23:0] last_cnt;
  logic [3:0][2:0] last_src;
  logic [3:0]      seen = 4'h0;

  always #4 clk = ~clk;

  lane_crossbar lane_crossbar_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .physical_serial_input_valid(in_valid), .physical_serial_input_data(in_data),
    .physical_serial_input_ready(in_ready), .logical_lane_valid(lane_valid),
    .logical_lane_data(lane_data), .logical_lane_ready(lane_ready));
  lane_tx_model lane_tx_model_i (.clk(clk), .reset(reset), .enable(tx_en), .slow(tx_slow),
    .valid(in_valid), .data(in_data), .ready(in_ready));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Register writes also update the routing model, from the taking edge on.
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    if (a == 10'h30a) sel45_m <= sel_reg_t'({2'h0, d[5:0]});
    if (a == 10'h30b) sel67_m <= sel_reg_t'({2'h0, d[5:0]});
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    check(32'(reg_rdata), 32'(exp));
  endtask

  function automatic logic [2:0] src_of(input int k);
    case (k)
      0: return sel45_m.lo;
      1: return sel45_m.hi;
      2: return sel67_m.lo;
      default: return sel67_m.hi;
    endcase
  endfunction

  function automatic logic [7:0] used_mask();
    used_mask = 8'h0;
    for (int k = 0; k < 4; k++) used_mask[src_of(k)] = 1'b1;
  endfunction

  // Consumers stall at random unless draining; each taken word is traced to
  // its input, and a lane that keeps its source must see no word lost or doubled.
  always @(posedge clk) begin
    lane_ready <= drain ? 4'hf : 4'($urandom);
    for (int k = 0; k < 4; k++) begin
      if (reset) begin
        seen[k] <= 1'b0;
      end else if (lane_valid[k] && lane_ready[k]) begin
        check(32'(lane_data[k][31:24]), 32'(src_of(k)));
        if (seen[k] && last_src[k] == src_of(k)) check(32'(lane_data[k][23:0]), 32'(last_cnt[k] + 24'h1));
        seen[k] <= 1'b1;
        last_src[k] <= src_of(k);
        last_cnt[k] <= lane_data[k][23:0];
      end
    end
  end

  // A hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [2:0] c;
    void'($urandom(32'hd8d4c636));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reg_rd(10'h30a, 8'h2c);
    reg_rd(10'h30b, 8'h3e);
    reg_rd(10'h30c, 8'h00);
    reg_rd(10'h30d, 8'hff);
    reg_rd(10'h30e, 8'h00);
    reg_wr(10'h30c, 8'h5a);
    reg_wr(10'h30d, 8'h5a);
    reg_rd(10'h30c, 8'h00);
    reg_rd(10'h30d, 8'hff);
    // Every code on every lane; lanes 5 and 7 share a source twice.
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      reg_wr(10'h30a, {2'h3, 3'(7 - i), c});
      reg_wr(10'h30b, {2'h3, c + 3'h5, c + 3'h2});
      reg_rd(10'h30a, {2'h0, 3'(7 - i), c});
      reg_rd(10'h30b, {2'h0, c + 3'h5, c + 3'h2});
      tx_slow <= 1'($urandom);
      tx_en <= 8'hff;
      drain <= 1'b0;
      repeat (60) @(posedge clk);
      tx_en <= 8'h00;
      drain <= 1'b1;
      repeat (40) @(posedge clk);
      reg_rd(10'h30c, ~used_mask());
      reg_rd(10'h30d, used_mask());
    end
    // Read and write together: the read returns the old value.
    reg_addr <= 10'h30a;
    reg_wdata <= 8'h00;
    reg_write <= 1'b1;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    sel45_m <= sel_reg_t'(8'h00);
    @(posedge clk);
    check(32'(reg_rdata), 32'h07);
    // Reset in mid-traffic brings back the defaults. The sources share the reset and
    // start sending again after release, so the first words after it take the reset routing.
    tx_slow <= 1'b0;
    tx_en <= 8'hff;
    drain <= 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b1;
    sel45_m <= sel_reg_t'(8'h2c);
    sel67_m <= sel_reg_t'(8'h3e);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reg_rd(10'h30a, 8'h2c);
    reg_rd(10'h30b, 8'h3e);
    reg_rd(10'h30c, 8'h00);
    repeat (40) @(posedge clk);
    tx_en <= 8'h00;
    drain <= 1'b1;
    repeat (40) @(posedge clk);
    reg_rd(10'h30c, ~used_mask());
    reg_rd(10'h30d, used_mask());
    print_verdict();
  end
endmodule // lane_crossbar_tb
